// >>> rtl/sra_pkg.sv
// Package: register map, field layout, reset values and state codes of the standby RAM array
`default_nettype none
package sra_pkg;

  // Register block: eight bytes, two 16-bit registers packed per 32-bit bus word
  localparam logic [23:0] SRA_REG_BASE_DEF  = 24'hFF_FB40;
  localparam logic        SRA_WORD_CFG      = 1'b0;   // Config (lanes 1:0), test (lanes 3:2)
  localparam logic        SRA_WORD_BASE     = 1'b1;   // Base high (lanes 1:0), base low (3:2)

  // Module config field positions
  localparam int          SRA_CFG_STOP_BIT  = 15;
  localparam int          SRA_CFG_LOCK_BIT  = 9;
  localparam int          SRA_CFG_SPACE_LSB = 6;
  localparam int          SRA_CFG_STBY_BIT  = 0;

  // Reset values
  localparam logic        SRA_STOP_RST      = 1'b1;
  localparam logic        SRA_LOCK_RST      = 1'b0;
  localparam logic [1:0]  SRA_SPACE_RST     = 2'b11;
  localparam logic [7:0]  SRA_BASEH_RST     = 8'h00;
  localparam logic [15:0] SRA_BASEL_RST     = 16'h0000;

  // Base range the processor cannot reach
  localparam logic [23:0] SRA_UNREACH_LO    = 24'h08_0000;
  localparam logic [23:0] SRA_UNREACH_HI    = 24'hF7_FFFF;

  // Array capacity in bytes
  localparam int          SRA_SIZE_DEF      = 1024;

  typedef struct packed {
    logic       stop;
    logic       lock;
    logic [1:0] space;
  } sra_cfg_t;

  typedef enum logic [3:0] {
    SRA_IDLE = 4'b0001,
    SRA_ACC1 = 4'b0010,
    SRA_ACC2 = 4'b0100,
    SRA_DONE = 4'b1000
  } sra_state_t;

endpackage
`default_nettype wire

// >>> rtl/sra_array.sv
// Standby RAM array module: control registers, relocatable RAM array, classic Wishbone slave
//
// How it works
// R1: Array capacity is a build parameter: 1, 2 or 4 Kbytes.
// R2: Array base is any multiple of its size; software keeps it off register blocks.
// R3: Array reads and writes work at byte, word and long-word widths.
// R4: Register block spans eight bytes; unimplemented locations read zero, ignore writes.
// R5: Base registers take writes only while stop is 1 and lock is 0.
// R6: Lock bit sets to one once; further writes ignored until reset.
// R7: A base inside the unreachable range leaves the array unreachable until remapped.
// R8: Space type low bit 0 answers program and data; 1 answers program only.
// R9: Space type upper bit has no effect on decoding.
// R10: Byte or aligned word takes one two-clock cycle; long or misaligned takes two.
// R11: While running from standby supply, all array accesses are refused.
// R12: Reset sets stop, program-only space, clears both base registers and lock.
// R13: A reset during a byte or word array access lets that access finish first; a misaligned word ends after its first half (here only for a reset in that half).
// R14: Reset in first half of a long word finishes that half; in second, all.
// R15: While stopped the array answers only with an error; registers still answer.
`default_nettype none
module sra_array
  import sra_pkg::*;
#(
  parameter int          SIZE_BYTES = sra_pkg::SRA_SIZE_DEF,   // R1
  parameter logic [23:0] REG_BASE   = sra_pkg::SRA_REG_BASE_DEF
) (
  // Clock and reset
  input  wire  logic        clk_i,
  input  wire  logic        rst_i,
  // Wishbone classic slave
  input  wire  logic        cyc_i,
  input  wire  logic        stb_i,
  input  wire  logic        we_i,
  input  wire  logic [23:2] adr_i,
  input  wire  logic [3:0]  sel_i,
  input  wire  logic [31:0] dat_i,
  input  wire  logic        prog_space_i,
  output var   logic [31:0] dat_o,
  output var   logic        ack_o,
  output var   logic        err_o,
  // Supply indication pin
  input  wire  logic        standby_supply_input_i,
  output var   logic        standby_o
);

  import sra_pkg::*;

  localparam int AW    = $clog2(SIZE_BYTES);
  localparam int HDEPTH = SIZE_BYTES / 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  sel2);
    logic [15:0] r;
    r = old_v;
    if (sel2[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (sel2[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction

  // Base bits below the array size are ignored, so every base lands on a size boundary
  function automatic logic [23:0] size_mask();
    logic [23:0] m;
    m = ~((24'h00_0001 << AW) - 24'h00_0001);
    return m;
  endfunction

  // Register block covers eight bytes and wins over an array placed on top of it
  function automatic logic reg_block_hit(input logic [23:0] a);
    return a[23:3] == REG_BASE[23:3];
  endfunction

  // Address bits 23:20 always copy bit 19, so a base in this span is never addressed
  function automatic logic base_unreachable(input logic [23:0] b);
    return (b >= SRA_UNREACH_LO) && (b <= SRA_UNREACH_HI);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Standby supply synchroniser: change accepted once stages two and three agree

  logic sby_s1;
  logic sby_s2;
  logic sby_s3;
  logic standby;

  always_ff @(posedge clk_i) begin
    sby_s1 <= standby_supply_input_i;
    sby_s2 <= sby_s1;
    sby_s3 <= sby_s2;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      standby <= 1'b0;
    end else if (sby_s2 == sby_s3) begin
      standby <= sby_s3;
    end
  end

  // Registered copy for the pin; the decode uses the internal flag directly
  always_ff @(posedge clk_i) begin
    standby_o <= standby;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and state

  sra_cfg_t    cfg;
  logic [7:0]  base_high;
  logic [15:0] base_low;
  sra_state_t  state;
  logic        rst_pend;
  logic        half;
  logic        two_halves;
  logic        busy;
  logic        apply_rst;
  logic        req;
  logic        reg_hit;
  logic        arr_hit;
  logic [23:0] byte_adr;
  logic [23:0] arr_base;
  logic [15:0] mem [HDEPTH];
  logic [AW-2:0] hidx;
  logic [15:0] wr_half;
  logic [1:0]  sel_half;
  logic        more_half;

  assign byte_adr = {adr_i, 2'b00};
  assign arr_base = {base_high, base_low} & size_mask();   // R2
  assign req      = cyc_i & stb_i;

  // Register accesses finish in one cycle and never hold back a reset
  always_comb begin
    case (state)
      SRA_ACC1, SRA_ACC2: busy = 1'b1;
      default:            busy = 1'b0;
    endcase
  end

  // Reset is held back while an array access runs, then applied once the sequencer reaches DONE
  assign apply_rst = (rst_i | rst_pend) & ~busy;   // R13

  // A long word goes on to its upper half unless a reset is waiting
  assign more_half = two_halves && !half && !(rst_i || rst_pend);   // R14

  // Held until the access in flight lets go
  always_ff @(posedge clk_i) begin
    if (apply_rst) begin
      rst_pend <= 1'b0;
    end else if (rst_i) begin
      rst_pend <= 1'b1;   // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Refusal order: stop, then supply, then placement, then space type
  always_comb begin
    reg_hit = 1'b0;
    arr_hit = 1'b0;
    if (reg_block_hit(byte_adr)) begin
      reg_hit = 1'b1;   // Registers win over an overlapping array
    end else if (cfg.stop) begin
      arr_hit = 1'b0;   // R15
    end else if (standby) begin
      arr_hit = 1'b0;   // R11
    end else if (base_unreachable(arr_base)) begin
      arr_hit = 1'b0;   // R7
    end else if ((byte_adr & size_mask()) == arr_base) begin
      arr_hit = ~cfg.space[0] | prog_space_i;   // R8 R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Access sequencer: each half-word cycle spends ACC1 and ACC2

  always_ff @(posedge clk_i) begin
    if (apply_rst) begin
      state <= SRA_IDLE;
    end else begin
      case (state)
        SRA_IDLE: begin
          if (req && arr_hit) begin
            state <= SRA_ACC1;
          end else if (req) begin
            state <= SRA_DONE;
          end
        end
        SRA_ACC1: begin
          state <= SRA_ACC2;   // R10
        end
        SRA_ACC2: begin
          if (more_half) begin
            state <= SRA_ACC1;   // R10
          end else begin
            state <= SRA_DONE;   // R14
          end
        end
        SRA_DONE: begin
          state <= SRA_IDLE;
        end
        default: begin
          state <= SRA_IDLE;
        end
      endcase
    end
  end

  // Half selection: lanes 1:0 first, lanes 3:2 second
  // Sampled every idle cycle, so the value belongs to the request being taken
  always_ff @(posedge clk_i) begin
    if (state == SRA_IDLE) begin
      two_halves <= (sel_i[1:0] != 2'b00) && (sel_i[3:2] != 2'b00);   // R10
      half       <= (sel_i[1:0] == 2'b00);
    end else if (state == SRA_ACC2) begin
      half <= 1'b1;
    end
  end

  assign hidx     = {byte_adr[AW-1:2], half};
  assign wr_half  = half ? dat_i[31:16] : dat_i[15:0];
  assign sel_half = half ? sel_i[3:2] : sel_i[1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Array storage

  // Stored on the second clock of each half-word cycle
  always_ff @(posedge clk_i) begin
    if (state == SRA_ACC2 && we_i) begin
      mem[hidx] <= merge16(mem[hidx], wr_half, sel_half);   // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic reg_wr;
  logic [15:0] cfg_wr;

  assign reg_wr = (state == SRA_IDLE) && !apply_rst && req && reg_hit && we_i;
  assign cfg_wr = merge16(16'h0000, dat_i[15:0], sel_i[1:0]);

  always_ff @(posedge clk_i) begin
    if (apply_rst) begin
      cfg.stop  <= SRA_STOP_RST;    // R12
      cfg.space <= SRA_SPACE_RST;   // R12
    end else if (reg_wr && adr_i[2] == SRA_WORD_CFG) begin
      if (sel_i[1]) begin
        cfg.stop <= cfg_wr[SRA_CFG_STOP_BIT];
      end
      if (sel_i[0]) begin
        cfg.space <= cfg_wr[SRA_CFG_SPACE_LSB +: 2];
      end
    end
  end

  // Lock only ever rises: a later write of zero is ignored until reset
  always_ff @(posedge clk_i) begin
    if (apply_rst) begin
      cfg.lock <= SRA_LOCK_RST;   // R12
    end else if (reg_wr && adr_i[2] == SRA_WORD_CFG && sel_i[1] && !cfg.lock) begin
      cfg.lock <= cfg_wr[SRA_CFG_LOCK_BIT];   // R6
    end
  end

  // Base moves only while stopped and unlocked, so no access sees a half-written base
  always_ff @(posedge clk_i) begin
    if (apply_rst) begin
      base_high <= SRA_BASEH_RST;   // R12
      base_low  <= SRA_BASEL_RST;   // R12
    end else if (reg_wr && adr_i[2] == SRA_WORD_BASE && cfg.stop && !cfg.lock) begin   // R5
      if (sel_i[0]) begin
        base_high <= dat_i[7:0];
      end
      base_low <= merge16(base_low, dat_i[31:16], sel_i[3:2]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data and answer

  logic [15:0] cfg_rd;

  // Standby bit is read-only; writes to it are dropped
  always_comb begin
    cfg_rd                              = 16'h0000;
    cfg_rd[SRA_CFG_STOP_BIT]            = cfg.stop;
    cfg_rd[SRA_CFG_LOCK_BIT]            = cfg.lock;
    cfg_rd[SRA_CFG_SPACE_LSB +: 2]      = cfg.space;
    cfg_rd[SRA_CFG_STBY_BIT]            = standby;
  end

  // Array half-words the access does not touch read zero; a read half-word comes back whole, both bytes
  always_ff @(posedge clk_i) begin
    if (apply_rst) begin
      dat_o <= 32'h0000_0000;
    end else if (state == SRA_IDLE && req && reg_hit && !we_i) begin
      if (adr_i[2] == SRA_WORD_CFG) begin
        dat_o <= {16'h0000, cfg_rd};   // R4
      end else begin
        dat_o <= {base_low, 8'h00, base_high};
      end
    end else if (state == SRA_IDLE && req) begin
      dat_o <= 32'h0000_0000;
    end else if (state == SRA_ACC2 && !we_i) begin
      if (half) begin
        dat_o[31:16] <= mem[hidx];
      end else begin
        dat_o[15:0] <= mem[hidx];
      end
    end
  end

  // A pending reset ends a long word after its first half; that half is still answered
  always_ff @(posedge clk_i) begin
    if (apply_rst) begin
      ack_o <= 1'b0;
    end else if (state == SRA_IDLE && req) begin
      ack_o <= reg_hit;
    end else if (state == SRA_ACC2) begin
      ack_o <= !more_half;   // R10 R14
    end else begin
      ack_o <= 1'b0;
    end
  end

  // Refusals answer in one cycle and never start the array
  always_ff @(posedge clk_i) begin
    if (apply_rst) begin
      err_o <= 1'b0;
    end else if (state == SRA_IDLE && req) begin
      err_o <= ~reg_hit & ~arr_hit;   // R11 R15
    end else begin
      err_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> tb/sra_array_asserts.sv
// Checker: answer timing of the standby RAM array bus
`default_nettype none
module sra_array_asserts #(
  parameter logic [23:0] REG_BASE = sra_pkg::SRA_REG_BASE_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic [23:2] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  input  wire logic        err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic go  = cyc_i && stb_i;
  wire logic rg  = adr_i[23:3] == REG_BASE[23:3];
  wire logic two = (sel_i[1:0] != 2'b00) && (sel_i[3:2] != 2'b00);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK: assert property (ack_o |=> !ack_o) else $error("ack stood two cycles");
  AST_ERR: assert property (err_o |=> !err_o) else $error("err stood two cycles");
  AST_ONE: assert property (!(ack_o && err_o)) else $error("ack and err together");
  AST_HELD: assert property ((ack_o || err_o) |-> go) else $error("answer unasked");
  AST_REG: assert property ($rose(go) && rg |=> ack_o) else $error("register late");
  AST_HALF: assert property ($rose(go) && !rg && !two |=> err_o or ((!ack_o)[*2] ##1 ack_o))
    else $error("single cycle array timing");
  AST_LONG: assert property ($rose(go) && !rg && two |=> err_o or ((!ack_o)[*4] ##1 ack_o))
    else $error("double cycle array timing");
  AST_RST: assert property (disable iff (1'b0) rst_i[*8] |-> !ack_o && dat_o == 32'h0000_0000)
    else $error("bus active in reset");
endmodule
bind sra_array sra_array_asserts #(.REG_BASE(REG_BASE)) sra_array_asserts_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o));
`default_nettype wire

// >>> tb/sra_core_model.sv
// Core model: processor-side classic Wishbone master
`default_nettype none
module sra_core_model (
  // Clock and answer
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  // Request
  output var  logic        cyc_o,
  output var  logic        stb_o,
  output var  logic        we_o,
  output var  logic [23:2] adr_o,
  output var  logic [3:0]  sel_o,
  output var  logic [31:0] dat_o,
  output var  logic        prog_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o, prog_o} = '0;
  end
  task automatic xfer(input logic w, input logic [23:0] a, input logic [3:0] s,
                      input logic [31:0] d, input logic p);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o, prog_o} <= {2'b11, w, a[23:2], s, d, p};
    do @(posedge clk_i); while (ack_i !== 1'b1 && err_i !== 1'b1);
    {cyc_o, stb_o} <= 2'b00;
    // Released data turns over so a stale value is never mistaken for a drive
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Testbench: exercises the standby RAM array through the core model
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sra_pkg::*;
  typedef struct packed {logic e; logic [31:0] m; logic [31:0] d;} sra_exp_t;
  localparam logic [23:0] RB = SRA_REG_BASE_DEF;
  localparam logic [23:0] RW = SRA_REG_BASE_DEF + 24'h00_0004;
  localparam logic [23:0] AB = 24'h00_1000;
  logic        clk_i, rst_i, sby, cyc, stb, we, prog, ack, err, sby_o;
  logic [23:2] adr;
  logic [3:0]  sel;
  logic [31:0] wd, rdat, d, k0, k1;
  logic [3:0]  lanes [8] = '{4'h6, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
  integer      n_errors = 0, checks_done = 0, seed = 32'hc864;
  sra_exp_t    x, expq[$];
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  sra_array #(.SIZE_BYTES(1024)) sra_array_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .prog_space_i(prog),
    .dat_o(rdat), .ack_o(ack), .err_o(err), .standby_supply_input_i(sby), .standby_o(sby_o));
  sra_core_model sra_core_model_i (.clk_i(clk_i), .ack_i(ack), .err_i(err), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd), .prog_o(prog));
  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  always @(posedge clk_i) begin
    if (ack === 1'b1 || err === 1'b1) begin
      x = (expq.size() > 0) ? expq.pop_front() : '1;
      chk("bus answer", {x.e, x.d}, {err, rdat & x.m});
    end
  end
  task automatic op(input logic w, input logic [23:0] a, input logic [3:0] s,
                    input logic [31:0] wv, input logic p, input logic e, input logic [31:0] xd);
    logic [31:0] m;
    m = (w || e) ? 32'h0000_0000 : {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    expq.push_back('{e, m, xd & m});
    sra_core_model_i.xfer(w, a, s, wv, p);
  endtask
  task automatic wr(input logic [23:0] a, input logic [3:0] s, input logic [31:0] v,
                    input logic e);
    op(1'b1, a, s, v, 1'b0, e, 32'h0000_0000);
  endtask
  task automatic rd(input logic [23:0] a, input logic [3:0] s, input logic [31:0] v,
                    input logic e);
    op(1'b0, a, s, 32'h0000_0000, 1'b0, e, v);
  endtask
  task automatic place(input logic [23:0] b);
    wr(RB, 4'h3, 32'h0000_8000, 1'b0);
    wr(RW, 4'hF, {b[15:0], 8'h00, b[23:16]}, 1'b0);
    wr(RB, 4'h3, 32'h0000_0000, 1'b0);
  endtask
  task automatic rst_mid(input int k, input logic [3:0] s, input logic [31:0] v);
    fork
      wr(AB, s, v, 1'b0);
      begin
        repeat (k) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
      end
    join
    repeat (4) @(posedge clk_i);
    place(AB);
  endtask
  task automatic conclude();
    chk("queue left", 33'h0, 33'(expq.size()));
    $display("Counts: %0d compares, %0d mismatches", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    conclude();
  end
  initial begin
    rst_i = 1'b1;
    sby = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(RB, 4'hF, 32'h0000_80C0, 1'b0);
    rd(RW, 4'hF, 32'h0000_0000, 1'b0);
    rd(AB, 4'hF, 32'h0000_0000, 1'b1);
    rd(RB + 24'h00_0008, 4'h3, 32'h0000_0000, 1'b1);
    wr(RW, 4'hF, 32'h1000_FF00, 1'b0);
    rd(RW, 4'hF, 32'h1000_0000, 1'b0);
    wr(RB, 4'hF, 32'hFFFF_0200, 1'b0);
    rd(RB, 4'hF, 32'h0000_0200, 1'b0);
    wr(RW, 4'hF, 32'h2000_0000, 1'b0);
    wr(RB, 4'h3, 32'h0000_8000, 1'b0);
    wr(RW, 4'hF, 32'h2000_0000, 1'b0);
    rd(RB, 4'h3, 32'h0000_8200, 1'b0);
    rd(RW, 4'hF, 32'h1000_0000, 1'b0);
    wr(RB, 4'h3, 32'h0000_0200, 1'b0);
    $display("Test registers done");
    foreach (lanes[i]) begin
      d = $random(seed);
      wr(AB + 24'h00_0008, lanes[i], d, 1'b0);
      rd(AB + 24'h00_0008, lanes[i], d, 1'b0);
    end
    for (int sp = 0; sp < 4; sp++) begin
      wr(RB, 4'h3, {24'h00_0002, 2'(sp), 6'h00}, 1'b0);
      op(1'b0, AB + 24'h00_0008, 4'h1, 32'h0000_0000, 1'b1, 1'b0, d);
      rd(AB + 24'h00_0008, 4'h1, d, sp[0]);
    end
    wr(RB, 4'h3, 32'h0000_0200, 1'b0);
    sby <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("standby flag", 33'h1, {32'h0000_0000, sby_o});
    rd(AB + 24'h00_0008, 4'h1, d, 1'b1);
    rd(RB, 4'h3, 32'h0000_0201, 1'b0);
    sby <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(AB + 24'h00_0008, 4'h1, d, 1'b0);
    $display("Test array access done");
    k0 = $random(seed);
    wr(AB, 4'hF, k0, 1'b0);
    k1 = $random(seed);
    rst_mid(1, 4'hF, k1);
    rd(AB, 4'hF, {k0[31:16], k1[15:0]}, 1'b0);
    k1 = $random(seed);
    rst_mid(3, 4'hF, k1);
    rd(AB, 4'hF, k1, 1'b0);
    rst_mid(1, 4'hC, ~k1);
    rd(AB, 4'hF, {~k1[31:16], k1[15:0]}, 1'b0);
    place(24'h08_0000);
    rd(24'h08_0000, 4'h1, 32'h0000_0000, 1'b1);
    place(AB);
    rd(AB, 4'h3, k1, 1'b0);
    $display("Test reset and mapping done");
    repeat (4) @(posedge clk_i);
    conclude();
  end
endmodule
`default_nettype wire
